//--- design/tccc_top.sv
// Conversion control, fault qualification, calibration and serial register access
//
// Function
// - One-shot pointer write in shutdown starts one cycle
// - Triggered cycle converts only enabled channels
// - Return to shutdown after the triggered cycle
// - One-shot data byte is ignored, never stored
// - Channel enable at pointer 16h, bits 0/1
// - Both enables reset to one; clear suppresses
// - Disabled channel's conversion slot is skipped
// - Run-length register 22h codes 01/03/07/0F
// - One run length serves both channels
// - Alert after programmed run above high limit
// - Same run qualification below low limit
// - Signed ideality byte at pointer 23h
// - Remote scaled by (2088 + N) / 2088
// - Ideality byte resets to zero
// - Ideality correction touches remote only
// - Remote offset added on every remote conversion
// - Pointer FEh reads fixed maker code
// - Shutdown waits for current sequence end
`timescale 1ns/1ps

module tccc_top
  import tccc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter logic [7:0] MAKER_ID = MAKER_ID_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             adc_start,
  output logic             adc_remote,
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_data,
  input  wire logic [15:0] local_high_limit,
  input  wire logic [15:0] local_low_limit,
  input  wire logic [15:0] remote_high_limit,
  input  wire logic [15:0] remote_low_limit,
  output logic [15:0]      local_result,
  output logic [15:0]      remote_result,
  output logic             busy,
  output logic             alert_n
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]      scl_sync;
    logic [2:0]      sda_sync;
    tccc_link_e      ist;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic [7:0]      ptr;
    logic            have_ptr;
    logic            rw;
    logic            sda_oe;
    logic [7:0]      cfg;
    logic [7:0]      channel_conversion_enable;
    logic [7:0]      fault_run_length;
    logic [7:0]      ideality_correction;
    logic [15:0]     remote_offset_trim;
    logic            one_shot;
    tccc_conv_e      cst;
    logic            adc_start;
    logic            adc_remote;
    logic [15:0]     local_result;
    logic [15:0]     remote_result;
    logic [3:0][2:0] cnt;
    logic            alert;
  } tccc_state_s;

  // Synchronisers start at the idle bus level, so reset gives no false edge
  localparam tccc_state_s ST_RST = '{
    scl_sync:                  '1,
    sda_sync:                  '1,
    ist:                       I_IDLE,
    cst:                       C_IDLE,
    cfg:                       CFG_RESET,
    channel_conversion_enable: CH_EN_RESET,
    fault_run_length:          FAULT_RUN_RESET,
    ideality_correction:       IDEAL_RESET,
    remote_offset_trim:        OFS_RESET,
    default:                   '0
  };

  tccc_state_s s;
  tccc_state_s nx;

  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  logic              sda_now;
  logic              shutdown_control_bit;
  logic              local_channel_on;
  logic              remote_channel_on;
  logic [2:0]        need;
  logic signed [31:0] scale;
  logic signed [31:0] prod;
  logic [15:0]       local_c;
  logic [15:0]       remote_c;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] run_count(input logic [7:0] code);
    if (code == RUN_CODE_4) begin
      return RUN_4;
    end else if (code == RUN_CODE_3) begin
      return RUN_3;
    end else if (code == RUN_CODE_2) begin
      return RUN_2;
    end
    return RUN_1;  // Unlisted codes behave as a run of one
  endfunction

  function automatic logic [2:0] bump(input logic [2:0] cnt, input logic out,
                                      input logic [2:0] lim);
    if (!out) begin
      return 3'h0;
    end
    return (cnt < lim) ? 3'(cnt + 3'h1) : cnt;  // Saturate at the run length
  endfunction

  function automatic logic [7:0] reg_read(input tccc_state_s st, input logic [7:0] p);
    unique case (p)
      PTR_CFG_RD:    return st.cfg;
      PTR_CH_EN:     return st.channel_conversion_enable;
      PTR_FAULT_RUN: return st.fault_run_length;
      PTR_IDEAL:     return st.ideality_correction;
      PTR_OFS_HI:    return st.remote_offset_trim[15:8];
      PTR_OFS_LO:    return st.remote_offset_trim[7:0];
      PTR_MAKER:     return MAKER_ID;
      default:       return READ_NONE;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Decode of synchronised link and result arithmetic
  // ------------------------------------------------------------
  // Stage 0 feeds stage 1 only; edges come from stages 1 and 2
  assign scl_rise   = s.scl_sync[1] & ~s.scl_sync[2];
  assign scl_fall   = ~s.scl_sync[1] & s.scl_sync[2];
  assign sda_now    = s.sda_sync[1];
  assign start_cond = s.scl_sync[1] & s.scl_sync[2] & ~s.sda_sync[1] & s.sda_sync[2];
  assign stop_cond  = s.scl_sync[1] & s.scl_sync[2] & s.sda_sync[1] & ~s.sda_sync[2];

  assign shutdown_control_bit = s.cfg[CFG_SHUTDOWN_BIT];
  assign local_channel_on     = s.channel_conversion_enable[CH_LOCAL_BIT];
  assign remote_channel_on    = s.channel_conversion_enable[CH_REMOTE_BIT];
  assign need                 = run_count(s.fault_run_length);

  // Correction acts on absolute temperature, before the Celsius shift
  assign scale    = IDEAL_BASE + 32'($signed(s.ideality_correction));
  assign prod     = $signed({16'h0000, adc_data}) * scale;
  assign remote_c = 16'(prod / IDEAL_BASE) - KELVIN_TIMES16 + s.remote_offset_trim;
  assign local_c  = adc_data - KELVIN_TIMES16;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nx           = s;
    nx.scl_sync  = {s.scl_sync[1:0], scl_in};
    nx.sda_sync  = {s.sda_sync[1:0], sda_in};
    nx.adc_start = 1'b0;

    // Conversion sequencer; mode is sampled only between sequences
    unique case (s.cst)
      C_IDLE: begin
        if (!shutdown_control_bit || s.one_shot) begin
          nx.one_shot = 1'b0;
          if (local_channel_on) begin
            nx.adc_start  = 1'b1;
            nx.adc_remote = 1'b0;
            nx.cst        = C_LOCAL;
          end else if (remote_channel_on) begin
            nx.adc_start  = 1'b1;
            nx.adc_remote = 1'b1;
            nx.cst        = C_REMOTE;
          end
        end
      end
      C_LOCAL: begin
        if (adc_done) begin
          nx.local_result = local_c;
          nx.cnt[SLOT_LOC_HI] = bump(s.cnt[SLOT_LOC_HI],
            $signed(local_c) > $signed(local_high_limit), need);
          nx.cnt[SLOT_LOC_LO] = bump(s.cnt[SLOT_LOC_LO],
            $signed(local_c) < $signed(local_low_limit), need);
          if (remote_channel_on) begin
            nx.adc_start  = 1'b1;
            nx.adc_remote = 1'b1;
            nx.cst        = C_REMOTE;
          end else begin
            nx.cst = C_IDLE;
          end
        end
      end
      C_REMOTE: begin
        if (adc_done) begin
          nx.remote_result = remote_c;
          nx.cnt[SLOT_REM_HI] = bump(s.cnt[SLOT_REM_HI],
            $signed(remote_c) > $signed(remote_high_limit), need);
          nx.cnt[SLOT_REM_LO] = bump(s.cnt[SLOT_REM_LO],
            $signed(remote_c) < $signed(remote_low_limit), need);
          nx.cst = C_IDLE;
        end
      end
    endcase

    // Serial slave; a trigger set here wins over the clear above
    if (start_cond) begin
      nx.ist      = I_ADDR;
      nx.bitcnt   = 4'h0;
      nx.have_ptr = 1'b0;
      nx.sda_oe   = 1'b0;
    end else if (stop_cond) begin
      nx.ist    = I_IDLE;
      nx.sda_oe = 1'b0;
    end else begin
      unique case (s.ist)
        I_IDLE: begin
        end
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            nx.shreg  = {s.shreg[6:0], sda_now};
            nx.bitcnt = 4'(s.bitcnt + 4'h1);
          end else if (scl_fall && s.bitcnt == BYTE_BITS) begin
            nx.sda_oe = 1'b1;
            nx.ist    = I_ACK;
            if (s.ist == I_ADDR) begin
              nx.rw = s.shreg[0];
              if (s.shreg[7:1] != DEV_ADDR) begin
                nx.sda_oe = 1'b0;
                nx.ist    = I_IDLE;
              end
            end else if (!s.have_ptr) begin
              nx.ptr      = s.shreg;
              nx.have_ptr = 1'b1;
            end else begin
              unique case (s.ptr)
                PTR_CFG_WR:    nx.cfg       = s.shreg & CFG_WR_MASK;
                PTR_ONE_SHOT:  nx.one_shot  = s.one_shot | shutdown_control_bit;
                PTR_CH_EN:     nx.channel_conversion_enable = s.shreg & CH_EN_MASK;
                PTR_FAULT_RUN: nx.fault_run_length          = s.shreg;
                PTR_IDEAL:     nx.ideality_correction       = s.shreg;
                PTR_OFS_HI:    nx.remote_offset_trim[15:8]  = s.shreg;
                PTR_OFS_LO:    nx.remote_offset_trim[7:0]   = s.shreg & OFS_LO_MASK;
                default: begin
                end
              endcase
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            nx.bitcnt = 4'h0;
            if (s.rw) begin
              nx.shreg  = reg_read(s, s.ptr);
              nx.sda_oe = ~nx.shreg[7];
              nx.ist    = I_RD;
            end else begin
              nx.sda_oe = 1'b0;
              nx.ist    = I_WR;
            end
          end
        end
        I_RD: begin
          if (scl_rise) begin
            nx.bitcnt = 4'(s.bitcnt + 4'h1);
          end else if (scl_fall) begin
            if (s.bitcnt == BYTE_BITS) begin
              nx.sda_oe = 1'b0;
              nx.ist    = I_RACK;
            end else begin
              nx.shreg  = {s.shreg[6:0], 1'b0};
              nx.sda_oe = ~s.shreg[6];
            end
          end
        end
        I_RACK: begin
          if (scl_rise && sda_now) begin
            nx.ist = I_IDLE;  // Master ended the read
          end else if (scl_fall) begin
            nx.bitcnt = 4'h0;
            nx.shreg  = reg_read(s, s.ptr);
            nx.sda_oe = ~nx.shreg[7];
            nx.ist    = I_RD;
          end
        end
      endcase
    end

    // Alert follows the counters, so a new run length takes effect at once
    nx.alert = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (nx.cnt[i] >= run_count(nx.fault_run_length)) begin
        nx.alert = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= ST_RST;
    end else begin
      s <= nx;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sda_out       = 1'b0;  // Open drain: only ever pulls low
  assign sda_oe        = s.sda_oe;
  assign adc_start     = s.adc_start;
  assign adc_remote    = s.adc_remote;
  assign local_result  = s.local_result;
  assign remote_result = s.remote_result;
  assign busy          = (s.cst != C_IDLE);
  assign alert_n       = ~s.alert;

endmodule // tccc_top

//--- inc/tccc_pkg.sv
// Package: pointers, field layout, reset values and state codes of the sensor control block
package tccc_pkg;

  // ------------------------------------------------------------
  // Register pointers
  // ------------------------------------------------------------
  localparam logic [7:0] PTR_CFG_RD    = 8'h03;
  localparam logic [7:0] PTR_CFG_WR    = 8'h09;
  localparam logic [7:0] PTR_ONE_SHOT  = 8'h0f;
  localparam logic [7:0] PTR_OFS_HI    = 8'h11;
  localparam logic [7:0] PTR_OFS_LO    = 8'h12;
  localparam logic [7:0] PTR_CH_EN     = 8'h16;
  localparam logic [7:0] PTR_FAULT_RUN = 8'h22;
  localparam logic [7:0] PTR_IDEAL     = 8'h23;
  localparam logic [7:0] PTR_MAKER     = 8'hfe;

  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  CFG_RESET       = 8'h00;
  localparam logic [7:0]  CFG_WR_MASK     = 8'he4;
  localparam int          CFG_SHUTDOWN_BIT = 6;
  localparam logic [7:0]  CH_EN_RESET     = 8'h03;
  localparam logic [7:0]  CH_EN_MASK      = 8'h03;
  localparam int          CH_LOCAL_BIT    = 0;
  localparam int          CH_REMOTE_BIT   = 1;
  localparam logic [7:0]  FAULT_RUN_RESET = 8'h01;
  localparam logic [7:0]  IDEAL_RESET     = 8'h00;
  localparam logic [15:0] OFS_RESET       = 16'h0000;
  localparam logic [7:0]  OFS_LO_MASK     = 8'hf0;
  localparam logic [7:0]  READ_NONE       = 8'h00;

  // Run-length codes and the counts they stand for
  localparam logic [7:0] RUN_CODE_2 = 8'h03;
  localparam logic [7:0] RUN_CODE_3 = 8'h07;
  localparam logic [7:0] RUN_CODE_4 = 8'h0f;
  localparam logic [2:0] RUN_1      = 3'h1;
  localparam logic [2:0] RUN_2      = 3'h2;
  localparam logic [2:0] RUN_3      = 3'h3;
  localparam logic [2:0] RUN_4      = 3'h4;

  // Ideality arithmetic, results in 1/16 degree steps
  localparam int          IDEAL_BASE     = 2088;
  localparam logic [15:0] KELVIN_TIMES16 = 16'h1112;

  // Serial link
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h4c;
  localparam logic [7:0] MAKER_ID_DEFAULT = 8'h5a;  // Arbitrary value
  localparam logic [3:0] BYTE_BITS        = 4'h8;

  // Fault counter slots
  localparam int SLOT_LOC_HI = 0;
  localparam int SLOT_LOC_LO = 1;
  localparam int SLOT_REM_HI = 2;
  localparam int SLOT_REM_LO = 3;

  // ------------------------------------------------------------
  // State codes
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    I_IDLE = 6'h01,
    I_ADDR = 6'h02,
    I_WR   = 6'h04,
    I_ACK  = 6'h08,
    I_RD   = 6'h10,
    I_RACK = 6'h20
  } tccc_link_e;

  typedef enum logic [2:0] {
    C_IDLE   = 3'h1,
    C_LOCAL  = 3'h2,
    C_REMOTE = 3'h4
  } tccc_conv_e;

endpackage

//--- tb/tccc_checker.sv
// Checker: timing and result relations at the ports of the sensor control block
`timescale 1ns/1ps

module tccc_checker
  import tccc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        adc_start,
  input wire logic        adc_remote,
  input wire logic        adc_done,
  input wire logic [15:0] adc_data,
  input wire logic [15:0] local_result,
  input wire logic [15:0] remote_result,
  input wire logic        busy,
  input wire logic        alert_n
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_start_one_cycle: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  a_start_in_seq: assert property (adc_start |-> busy)
    else $error("conversion started outside a sequence");
  a_slot_after_done: assert property (adc_start && $past(busy) |-> $past(adc_done))
    else $error("next slot started before the previous one finished");
  a_seq_end_done: assert property ($fell(busy) |-> $past(adc_done))
    else $error("sequence ended without a finished conversion");
  a_channel_held: assert property (busy && !adc_start |-> $stable(adc_remote))
    else $error("channel select moved inside a conversion");
  a_local_exact: assert property (adc_done && !adc_remote |=>
    local_result == $past(adc_data) - KELVIN_TIMES16)
    else $error("local result not the plain conversion");
  a_remote_on_done: assert property ($changed(remote_result) |->
    $past(adc_done) && $past(adc_remote))
    else $error("remote result moved without a remote conversion");
  // Alert is registered alongside the counters, so it moves one edge after done; two edges are also allowed
  a_alert_on_result: assert property ($fell(alert_n) |->
    $past(adc_done) || $past(adc_done, 2))
    else $error("alert asserted without a new result");
  a_alert_clear: assert property ($rose(alert_n) |->
    $past(adc_done) || $past(adc_done, 2))
    else $error("alert released without a new result");

  c_remote_only: cover property (adc_start && adc_remote && !$past(busy));
  c_alert: cover property ($fell(alert_n));
  c_seq_end: cover property ($fell(busy));
endmodule // tccc_checker

bind tccc_top tccc_checker tccc_checker_i (
  .sys_clk(sys_clk), .resetn(resetn), .adc_start(adc_start), .adc_remote(adc_remote),
  .adc_done(adc_done), .adc_data(adc_data), .local_result(local_result),
  .remote_result(remote_result), .busy(busy), .alert_n(alert_n));

//--- tb/tccc_host.sv
// Two-wire bus host model reaching the sensor registers
`timescale 1ns/1ps

module tccc_host
  import tccc_pkg::*;
#(
  parameter logic [6:0] ADDR = DEV_ADDR_DEFAULT
) (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // Quarter of the 125 ns bus clock; SCL stands high between frames
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic put_bit(input logic b);
    sda_pull = !b;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
    #Q;
  endtask
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Serves as repeated start too: SDA released before SCL rises
  task automatic start;
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start;
    send({ADDR, 1'b0});
    send(p);
    send(d);
    stop;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    start;
    send({ADDR, 1'b0});
    send(p);
    start;
    send({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop;
  endtask
endmodule // tccc_host

//--- tb/tccc_top_test.sv
// Self-checking bench: registers, one-shot control, calibration and fault runs
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module tccc_top_test
  import tccc_pkg::*;
;
  localparam int ADC_LAT = 30;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        scl, sda_pull, sda_oe, sda_out, sda, was_busy;
  logic        adc_start, adc_remote, adc_done, busy, alert_n;
  logic [15:0] adc_data, local_result, remote_result;
  logic [15:0] loc_hi = 16'h7fff, loc_lo = 16'h8000, rem_hi = 16'h7fff, rem_lo = 16'h8000;
  logic [15:0] loc_raw = 16'h1300, rem_raw = 16'h1500;
  int          n_fail, comparisons, n_loc, n_rem, n_seq;

  assign sda = !sda_pull & (sda_oe ? sda_out : 1'b1);
  always #5 sys_clk = !sys_clk;

  tccc_host tccc_host_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  tccc_top tccc_top_i (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .adc_start(adc_start), .adc_remote(adc_remote),
    .adc_done(adc_done), .adc_data(adc_data), .local_high_limit(loc_hi),
    .local_low_limit(loc_lo), .remote_high_limit(rem_hi), .remote_low_limit(rem_lo),
    .local_result(local_result), .remote_result(remote_result), .busy(busy),
    .alert_n(alert_n));

  // ------------------------------------------------------------
  // Converter model and sequence counter
  // ------------------------------------------------------------
  initial begin
    adc_done = 1'b0;
    adc_data = 16'h0000;
    forever begin
      @(posedge sys_clk);
      if (adc_start === 1'b1) begin
        if (adc_remote === 1'b1) n_rem++;
        else n_loc++;
        repeat (ADC_LAT) @(posedge sys_clk);
        #1 adc_done = 1'b1;
        adc_data = (adc_remote === 1'b1) ? rem_raw : loc_raw;
        @(posedge sys_clk);
        #1 adc_done = 1'b0;
        // Data not held past done
        adc_data = ~adc_data;
      end
    end
  end
  always @(posedge sys_clk) begin
    #2;
    if (was_busy === 1'b1 && busy === 1'b0) n_seq++;
    was_busy = busy;
  end

  // ------------------------------------------------------------
  // Shared tasks and scenarios
  // ------------------------------------------------------------
  task automatic wait_to(input int t);
    for (int i = 0; i < 4000 && n_seq < t; i++) @(posedge sys_clk);
    #1;
    `CHK("sequences", 1'b1, n_seq >= t)
  endtask
  task automatic one_shot(input logic [7:0] d);
    int t;
    t = n_seq + 1;
    tccc_host_i.wr(PTR_ONE_SHOT, d);
    wait_to(t);
    repeat (150) @(posedge sys_clk);
    #1;
    `CHK("single run", t, n_seq)
  endtask
  task automatic chk_reg(input logic [7:0] p, input logic [7:0] ex);
    logic [7:0] d;
    tccc_host_i.rd(p, d);
    `CHK("register", ex, d)
  endtask
  task automatic set_lim(input logic [15:0] lh, input logic [15:0] rl);
    @(posedge sys_clk);
    #1 loc_hi = lh;
    rem_lo = rl;
  endtask
  task automatic t_reset;
    chk_reg(PTR_CH_EN, 8'h03);
    chk_reg(PTR_FAULT_RUN, 8'h01);
    chk_reg(PTR_IDEAL, 8'h00);
    chk_reg(PTR_MAKER, MAKER_ID_DEFAULT);
    chk_reg(8'h40, 8'h00);
    wait_to(n_seq + 2);
    `CHK("remote", rem_raw - KELVIN_TIMES16, remote_result)
    `CHK("local", loc_raw - KELVIN_TIMES16, local_result)
    $display("test reset values done");
  endtask
  task automatic t_shutdown;
    int s;
    tccc_host_i.wr(PTR_CFG_WR, 8'h40);
    chk_reg(PTR_CFG_RD, 8'h40);
    repeat (300) @(posedge sys_clk);
    #1;
    `CHK("busy", 1'b0, busy)
    `CHK("whole runs", n_loc, n_rem)
    s = n_loc + n_rem;
    repeat (300) @(posedge sys_clk);
    #1;
    `CHK("idle starts", s, n_loc + n_rem)
    for (int ch = 1; ch < 4; ch++) begin
      tccc_host_i.wr(PTR_CH_EN, 8'(ch));
      chk_reg(PTR_CH_EN, 8'(ch));
      n_loc = 0;
      n_rem = 0;
      one_shot(8'hc3 ^ 8'(ch));
      `CHK("local runs", ch & 1, n_loc)
      `CHK("remote runs", ch >> 1, n_rem)
    end
    chk_reg(PTR_ONE_SHOT, 8'h00);
    $display("test shutdown and one-shot done");
  endtask
  task automatic t_calib;
    int e;
    int n;
    tccc_host_i.wr(PTR_OFS_HI, 8'h01);
    tccc_host_i.wr(PTR_OFS_LO, 8'h2f);
    chk_reg(PTR_OFS_LO, 8'h20);
    for (int k = 0; k < 2; k++) begin
      n = (k == 0) ? -128 : 127;
      tccc_host_i.wr(PTR_IDEAL, 8'(n));
      chk_reg(PTR_IDEAL, 8'(n));
      one_shot(8'h00);
      e = (int'(rem_raw) * (IDEAL_BASE + n)) / IDEAL_BASE - int'(KELVIN_TIMES16) + 'h120;
      `CHK("remote", 16'(e), remote_result)
      `CHK("local", loc_raw - KELVIN_TIMES16, local_result)
      rem_raw = 16'h1400;
    end
    $display("test calibration done");
  endtask
  task automatic t_fault;
    logic [7:0] codes [4] = '{8'h01, 8'h03, 8'h07, 8'h0f};
    for (int k = 0; k < 4; k++) begin
      tccc_host_i.wr(PTR_FAULT_RUN, codes[k]);
      chk_reg(PTR_FAULT_RUN, codes[k]);
      set_lim(16'h0100, 16'h8000);
      for (int j = 0; j <= k; j++) begin
        one_shot(8'hff);
        `CHK("alert", j < k, alert_n)
      end
      set_lim(16'h7fff, 16'h8000);
      one_shot(8'h00);
      `CHK("alert", 1'b1, alert_n)
    end
    tccc_host_i.wr(PTR_FAULT_RUN, 8'h03);
    set_lim(16'h7fff, 16'h7000);
    for (int j = 0; j < 2; j++) begin
      one_shot(8'h3c);
      `CHK("alert", j < 1, alert_n)
    end
    set_lim(16'h7fff, 16'h8000);
    one_shot(8'h00);
    `CHK("alert", 1'b1, alert_n)
    tccc_host_i.wr(PTR_CFG_WR, 8'h00);
    wait_to(n_seq + 3);
    $display("test fault runs and resume done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset;
    t_shutdown;
    t_calib;
    t_fault;
    final_report;
  end
  // Scenarios need about 30k cycles; the limit leaves ample margin
  initial begin
    #600us;
    n_fail++;
    $display("watchdog expired");
    final_report;
  end
endmodule // tccc_top_test
